// ---- sps_pkg.sv ----
// constants, field positions and carrier types for the sync serial port
// assumes a 32-bit APB bus with byte addresses held in the low 8 bits
package sps_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BYTE_W = 8;

    // register byte addresses
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h94;
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h98;
    localparam logic [ADDR_W-1:0] OFS_BUF      = 8'h9C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'hA0;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'hA4;

    // serial_port_status fields
    localparam int unsigned ST_DATA_ADDR = 5;
    localparam int unsigned ST_STOP      = 4;
    localparam int unsigned ST_START     = 3;
    localparam int unsigned ST_DIR       = 2;
    localparam int unsigned ST_ADDR_UPD  = 1;
    localparam int unsigned ST_BUF_FULL  = 0;

    // port_control_reg fields
    localparam int unsigned CT_EN   = 5;
    localparam int unsigned CT_CKP  = 4;
    localparam int unsigned CT_I2C  = 0;
    localparam logic [BYTE_W-1:0] CTRL_RST  = 8'h00;
    localparam logic [BYTE_W-1:0] CTRL_MASK = 8'h31;

    // interrupt status / mask fields
    localparam int unsigned IRQ_W    = 3;
    localparam int unsigned IQ_BYTE  = 0;
    localparam int unsigned IQ_START = 1;
    localparam int unsigned IQ_STOP  = 2;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

    // receive bit counts
    localparam logic [3:0] SPI_LAST_BIT = 4'h7;
    localparam logic [3:0] I2C_LAST_BIT = 4'h8;

    typedef enum logic [2:0] {
        FR_IDLE = 3'b001,
        FR_ADDR = 3'b010,
        FR_DATA = 3'b100
    } sps_frame_e;

    typedef struct packed {
        logic sck;
        logic sd;
        logic ss_n;
    } sps_pin_in_s;

    typedef struct packed {
        logic              start;
        logic              stop;
        logic              byte_done;
        logic [BYTE_W-1:0] data;
    } sps_evt_s;

endpackage

// ---- sps_link.sv ----
// pin synchroniser, start/stop detector and 8-bit shifter of the serial port
// assumes pins are asynchronous to clk_i and toggle no faster than clk_i/4
`timescale 1ns/10ps
module sps_link (
    input  wire logic                      clk_i,
    input  wire logic                      nrst_i,
    input  wire logic                      enable_i,
    input  wire logic                      i2c_mode_i,
    input  wire logic                      ckp_i,
    input  wire sps_pkg::sps_pin_in_s      pins_i,
    input  wire logic                      tx_load_i,
    input  wire logic [sps_pkg::BYTE_W-1:0] tx_data_i,
    output sps_pkg::sps_evt_s              evt_o,
    output logic                           sdo_o
);
    import sps_pkg::*;

    sps_pin_in_s       sync1_q;
    sps_pin_in_s       sync2_q;
    sps_pin_in_s       prev_q;
    logic [BYTE_W-1:0] rx_q;
    logic [BYTE_W-1:0] tx_q;
    logic [3:0]        cnt_q;
    sps_evt_s          evt_q;
    logic              sdo_q;

    wire sck_rise   = sync2_q.sck & ~prev_q.sck;
    wire sck_fall   = ~sync2_q.sck & prev_q.sck;
    wire i2c_on     = enable_i & i2c_mode_i;
    wire spi_on     = enable_i & ~i2c_mode_i & ~sync2_q.ss_n;
    // sda may only move while scl is low; a move with scl high is a condition
    wire scl_high   = sync2_q.sck & prev_q.sck;
    wire start_det  = i2c_on & scl_high & prev_q.sd & ~sync2_q.sd;
    wire stop_det   = i2c_on & scl_high & ~prev_q.sd & sync2_q.sd;
    wire rx_edge    = i2c_on ? sck_rise : (spi_on & (ckp_i ? sck_rise : sck_fall));
    wire tx_edge    = spi_on & (ckp_i ? sck_fall : sck_rise);
    wire [3:0] last = i2c_mode_i ? I2C_LAST_BIT : SPI_LAST_BIT;
    // in i2c the ninth clock carries the acknowledge and is not shifted in
    wire shift_bit  = rx_edge & (cnt_q < SPI_LAST_BIT + 4'h1);
    wire byte_end   = rx_edge & (cnt_q == SPI_LAST_BIT);
    wire cnt_clr    = ~enable_i | start_det | (~i2c_mode_i & sync2_q.ss_n);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            // pins idle high, so no false edge after reset
            sync1_q <= '1;
            sync2_q <= '1;
            prev_q  <= '1;
        end else begin
            sync1_q <= pins_i;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_q  <= '0;
            cnt_q <= '0;
        end else if (cnt_clr) begin
            cnt_q <= '0;
        end else if (rx_edge) begin
            if (shift_bit) begin
                rx_q <= {rx_q[BYTE_W-2:0], sync2_q.sd};
            end
            cnt_q <= (cnt_q == last) ? 4'h0 : cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            evt_q <= '0;
        end else begin
            evt_q.start     <= start_det;
            evt_q.stop      <= stop_det;
            evt_q.byte_done <= byte_end & ~cnt_clr;
            if (byte_end & ~cnt_clr) begin
                evt_q.data <= {rx_q[BYTE_W-2:0], sync2_q.sd};
            end
        end
    end

    // msb first out of the transmit shifter in spi mode
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_q  <= '0;
            sdo_q <= 1'b0;
        end else begin
            if (tx_load_i) begin
                tx_q <= tx_data_i;
            end else if (tx_edge) begin
                tx_q <= {tx_q[BYTE_W-2:0], 1'b0};
            end
            sdo_q <= tx_q[BYTE_W-1];
        end
    end

    assign evt_o = evt_q;
    assign sdo_o = sdo_q;

endmodule

// ---- sps_port.sv ----
// sync serial port: APB register slave, status flags, i2c frame tracking
// and pin ownership between the port and general-purpose logic
// assumes APB master on clk_i and asynchronous serial pins
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps

// Summary of operation
// - one personality at a time: spi or i2c
// - status bits 7 and 6 read zero
// - start flag shows last condition was start
// - start flag i2c only, cleared on disable
// - start flag zero after reset
// - enable hands sck and sd to port (sdo only in spi), else gpio
// - full byte loads buffer, sets full and irq
// - buffer read clears buffer full flag
module sps_port (
    input  wire logic                        clk_i,
    input  wire logic                        nrst_i,
    input  wire logic                        psel_i,
    input  wire logic                        penable_i,
    input  wire logic                        pwrite_i,
    input  wire logic [sps_pkg::ADDR_W-1:0]  paddr_i,
    input  wire logic [sps_pkg::DATA_W-1:0]  pwdata_i,
    output logic      [sps_pkg::DATA_W-1:0]  prdata_o,
    output logic                             pready_o,
    output logic                             pslverr_o,
    input  wire logic                        pin_sck_i,
    input  wire logic                        pin_sd_i,
    input  wire logic                        pin_ss_n_i,
    output logic                             pin_sck_o,
    output logic                             pin_sck_oe_o,
    output logic                             pin_sd_o,
    output logic                             pin_sd_oe_o,
    output logic                             pin_sdo_o,
    output logic                             pin_sdo_oe_o,
    input  wire logic [2:0]                  gpio_out_i,
    input  wire logic [2:0]                  gpio_oe_i,
    output logic                             irq_o
);
    import sps_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    logic [BYTE_W-1:0] ctrl_q;
    logic [BYTE_W-1:0] rxbuf_q;
    logic [BYTE_W-1:0] txbuf_q;
    logic              buf_full_q;
    logic              start_q;
    logic              stop_q;
    logic              data_addr_q;
    logic              dir_q;
    sps_frame_e        frame_q;
    sps_frame_e        frame_d;
    logic [IRQ_W-1:0]  irq_stat_q;
    logic [IRQ_W-1:0]  irq_mask_q;
    logic [DATA_W-1:0] prdata_q;
    logic              tx_load_q;
    logic              sck_o_q;
    logic              sck_oe_q;
    logic              sd_o_q;
    logic              sd_oe_q;
    logic              sdo_o_q;
    logic              sdo_oe_q;
    sps_evt_s          evt;
    sps_pin_in_s       pins;
    logic              link_sdo;

    // bus decode
    wire setup      = psel_i & ~penable_i;
    wire access     = psel_i & penable_i;
    wire a_status   = hit(paddr_i, OFS_STATUS);
    wire a_ctrl     = hit(paddr_i, OFS_CTRL);
    wire a_buf      = hit(paddr_i, OFS_BUF);
    wire a_istat    = hit(paddr_i, OFS_IRQ_STAT);
    wire a_imask    = hit(paddr_i, OFS_IRQ_MASK);
    wire mapped     = a_status | a_ctrl | a_buf | a_istat | a_imask;
    wire bad_access = ~mapped | (pwrite_i & a_status);
    wire wr_ctrl    = access & pwrite_i & a_ctrl;
    wire wr_buf     = access & pwrite_i & a_buf;
    wire wr_istat   = access & pwrite_i & a_istat;
    wire wr_imask   = access & pwrite_i & a_imask;
    wire rd_buf     = access & ~pwrite_i & a_buf;

    wire enabled    = ctrl_q[CT_EN];
    wire i2c_mode   = ctrl_q[CT_I2C];
    wire i2c_on     = enabled & i2c_mode;

    // status word: top two bits have no storage
    wire [BYTE_W-1:0] status_word = {2'b00,
                                     data_addr_q,
                                     stop_q,
                                     start_q,
                                     dir_q,
                                     1'b0,
                                     buf_full_q};

    // seven-bit addressing only, so the address-update flag never rises
    wire [DATA_W-1:0] rd_mux =
        a_status ? {24'h000000, status_word} :
        a_ctrl   ? {24'h000000, ctrl_q} :
        a_buf    ? {24'h000000, rxbuf_q} :
        a_istat  ? {29'h00000000, irq_stat_q} :
        a_imask  ? {29'h00000000, irq_mask_q} :
                   32'h00000000;

    wire [IRQ_W-1:0] irq_set = {evt.stop & i2c_on, evt.start & i2c_on, evt.byte_done};
    wire [IRQ_W-1:0] irq_clr = wr_istat ? pwdata_i[IRQ_W-1:0] : 3'h0;

    assign pins = '{sck: pin_sck_i, sd: pin_sd_i, ss_n: pin_ss_n_i};

    sps_link i_sps_link (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .enable_i   (enabled),
        .i2c_mode_i (i2c_mode),
        .ckp_i      (ctrl_q[CT_CKP]),
        .pins_i     (pins),
        .tx_load_i  (tx_load_q),
        .tx_data_i  (txbuf_q),
        .evt_o      (evt),
        .sdo_o      (link_sdo)
    );

    // bus answer: one access cycle, read data captured in setup
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prdata_q <= '0;
        end else if (setup) begin
            prdata_q <= pwrite_i ? 32'h00000000 : rd_mux;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q     <= CTRL_RST;
            irq_mask_q <= IRQ_RST;
            txbuf_q    <= '0;
            tx_load_q  <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata_i[BYTE_W-1:0] & CTRL_MASK;
            end
            if (wr_imask) begin
                irq_mask_q <= pwdata_i[IRQ_W-1:0];
            end
            if (wr_buf) begin
                txbuf_q <= pwdata_i[BYTE_W-1:0];
            end
            tx_load_q <= wr_buf;
        end
    end

    // sticky interrupt bits, set beats a write-one clear
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_stat_q <= IRQ_RST;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end

    // receive buffer and full flag; a byte landing during the read wins
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rxbuf_q    <= '0;
            buf_full_q <= 1'b0;
        end else if (evt.byte_done) begin
            rxbuf_q    <= evt.data;
            buf_full_q <= 1'b1;
        end else if (rd_buf || !enabled) begin
            buf_full_q <= 1'b0;
        end
    end

    // last bus condition; disable or spi mode forces both low
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            start_q <= 1'b0;
            stop_q  <= 1'b0;
        end else if (!i2c_on) begin
            start_q <= 1'b0;
            stop_q  <= 1'b0;
        end else if (evt.start) begin
            start_q <= 1'b1;
            stop_q  <= 1'b0;
        end else if (evt.stop) begin
            start_q <= 1'b0;
            stop_q  <= 1'b1;
        end
    end

    // i2c frame: first byte after start is the address byte
    always_comb begin
        frame_d = frame_q;
        case (frame_q)
            FR_IDLE: begin
                if (evt.start) begin
                    frame_d = FR_ADDR;
                end
            end
            FR_ADDR: begin
                if (evt.stop) begin
                    frame_d = FR_IDLE;
                end else if (evt.byte_done) begin
                    frame_d = FR_DATA;
                end
            end
            FR_DATA: begin
                if (evt.stop) begin
                    frame_d = FR_IDLE;
                end else if (evt.start) begin
                    frame_d = FR_ADDR;
                end
            end
            default: begin
                frame_d = FR_IDLE;
            end
        endcase
        if (!i2c_on) begin
            frame_d = FR_IDLE;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            frame_q     <= FR_IDLE;
            data_addr_q <= 1'b0;
            dir_q       <= 1'b0;
        end else begin
            frame_q <= frame_d;
            if (!i2c_on) begin
                data_addr_q <= 1'b0;
                dir_q       <= 1'b0;
            end else if (evt.byte_done) begin
                data_addr_q <= (frame_q == FR_DATA);
                if (frame_q == FR_ADDR) begin
                    dir_q <= evt.data[0];
                end
            end else if (evt.stop) begin
                dir_q <= 1'b0;
            end
        end
    end

    // pin ownership; the port only listens on sck and sd, so no ack is driven
    wire       spi_sdo_own = enabled & ~i2c_mode;
    wire [5:0] pin_d = enabled ?
        {1'b0, 1'b0, 1'b0, 1'b0,
         spi_sdo_own ? link_sdo : gpio_out_i[2],
         spi_sdo_own | gpio_oe_i[2] & i2c_mode} :
        {gpio_out_i[0], gpio_oe_i[0], gpio_out_i[1], gpio_oe_i[1],
         gpio_out_i[2], gpio_oe_i[2]};

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {sck_o_q, sck_oe_q, sd_o_q, sd_oe_q, sdo_o_q, sdo_oe_q} <= 6'h00;
        end else begin
            {sck_o_q, sck_oe_q, sd_o_q, sd_oe_q, sdo_o_q, sdo_oe_q} <= pin_d;
        end
    end

    assign prdata_o     = prdata_q;
    assign pready_o     = access;
    assign pslverr_o    = access & bad_access;
    assign irq_o        = |(irq_stat_q & irq_mask_q);
    assign pin_sck_o    = sck_o_q;
    assign pin_sck_oe_o = sck_oe_q;
    assign pin_sd_o     = sd_o_q;
    assign pin_sd_oe_o  = sd_oe_q;
    assign pin_sdo_o    = sdo_o_q;
    assign pin_sdo_oe_o = sdo_oe_q;

endmodule

// ---- sps_port_sva.sv ----
// concurrent checks on the sync serial port top-level pins
// assumes bind to sps_port, one clk_i domain, zero-wait apb
`timescale 1ns/10ps
module sps_port_sva
    import sps_pkg::*;
(
    input wire logic                       clk_i,
    input wire logic                       nrst_i,
    input wire logic                       psel_i,
    input wire logic                       penable_i,
    input wire logic                       pwrite_i,
    input wire logic [sps_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [sps_pkg::DATA_W-1:0] pwdata_i,
    input wire logic [sps_pkg::DATA_W-1:0] prdata_o,
    input wire logic                       pslverr_o,
    input wire logic                       pin_sck_o,
    input wire logic                       pin_sck_oe_o,
    input wire logic                       pin_sd_oe_o,
    input wire logic                       pin_sdo_oe_o,
    input wire logic [2:0]                 gpio_out_i,
    input wire logic [2:0]                 gpio_oe_i,
    input wire logic                       irq_o
);
    // mirrors of control bits and of any set interrupt mask bit, rebuilt from the bus writes
    logic en_q;
    logic i2c_q;
    logic msk_q;
    wire  acc    = psel_i && penable_i;
    wire  wr_ctl = acc && pwrite_i && paddr_i == OFS_CTRL;
    wire  wr_msk = acc && pwrite_i && paddr_i == OFS_IRQ_MASK;
    wire  st_rd  = acc && !pwrite_i && paddr_i == OFS_STATUS;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            en_q  <= 1'b0;
            i2c_q <= 1'b0;
            msk_q <= 1'b0;
        end else begin
            if (wr_ctl) begin
                en_q  <= pwdata_i[CT_EN];
                i2c_q <= pwdata_i[CT_I2C];
            end
            if (wr_msk) begin
                msk_q <= |pwdata_i[IRQ_W-1:0];
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    gpio_own_a: assert property ($past(nrst_i) && !en_q && !$past(en_q) |->
        pin_sck_o == $past(gpio_out_i[0]) && pin_sck_oe_o == $past(gpio_oe_i[0]))
        else $error("disabled port does not pass gpio to pins");
    port_own_a: assert property (en_q && $past(en_q) |-> !pin_sck_oe_o && !pin_sd_oe_o)
        else $error("enabled port drives sck or sd");
    spi_sdo_a: assert property (en_q && !i2c_q && $past(en_q && !i2c_q) |-> pin_sdo_oe_o)
        else $error("spi personality does not drive sdo");
    i2c_sdo_a: assert property ($past(nrst_i) && en_q && i2c_q && $past(en_q && i2c_q)
        |-> pin_sdo_oe_o == $past(gpio_oe_i[2])) else $error("i2c personality drives sdo");
    top_zero_a: assert property (st_rd |-> prdata_o[31:6] == '0)
        else $error("status upper bits not zero");
    ro_status_a: assert property (acc && pwrite_i && paddr_i == OFS_STATUS |-> pslverr_o)
        else $error("status write not refused");
    dis_flags_a: assert property ((!en_q) [*4] ##0 st_rd |-> prdata_o[4:3] == 2'b00)
        else $error("start or stop flag set while disabled");
    irq_mask_a: assert property (!msk_q |-> !irq_o)
        else $error("interrupt raised with all sources masked");
endmodule

bind sps_port sps_port_sva i_sps_port_sva (
    .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pslverr_o(pslverr_o), .pin_sck_o(pin_sck_o), .pin_sck_oe_o(pin_sck_oe_o),
    .pin_sd_oe_o(pin_sd_oe_o), .pin_sdo_oe_o(pin_sdo_oe_o), .gpio_out_i(gpio_out_i),
    .gpio_oe_i(gpio_oe_i), .irq_o(irq_o)
);

// ---- sps_peer.sv ----
// behavioural serial bus controller on the port's far side
// assumes the bench wires sck, sd and ss_n to the port inputs
`timescale 1ns/10ps
module sps_peer #(
    parameter int HALF = 80
) (
    output logic sck_o,
    output logic sd_o,
    output logic ss_n_o
);
    // i2c lines idle high through pull-ups; clock still between frames
    initial begin
        sck_o  = 1'b1;
        sd_o   = 1'b1;
        ss_n_o = 1'b1;
    end

    task automatic i2c_start();
        #3;
        sd_o = 1'b1;
        #HALF sck_o = 1'b1;
        #HALF sd_o = 1'b0;
        #HALF sck_o = 1'b0;
    endtask

    task automatic i2c_stop();
        #3;
        sd_o = 1'b0;
        #HALF sck_o = 1'b1;
        #HALF sd_o = 1'b1;
    endtask

    // eight bits msb first, then a ninth clock with sd released
    task automatic i2c_byte(input logic [7:0] d);
        #3;
        for (int i = 0; i < 9; i++) begin
            sd_o = (i < 8) ? d[7-i] : 1'b1;
            #HALF sck_o = 1'b1;
            #HALF sck_o = 1'b0;
        end
    endtask

    // clock idles at ckp; leaving idle is the shift edge, returning samples
    task automatic spi_byte(input logic ckp, input logic [7:0] d);
        #3;
        sck_o  = ckp;
        // idle level settles before select, so no stray edge counts as a bit
        #HALF ss_n_o = 1'b0;
        for (int i = 0; i < 8; i++) begin
            #HALF sck_o = ~ckp;
            sd_o = d[7-i];
            #HALF sck_o = ckp;
        end
        #HALF ss_n_o = 1'b1;
        sd_o = ~sd_o;
    endtask
endmodule

// ---- sps_port_tb_top.sv ----
// self-checking bench: apb register sequences against a serial peer
// assumes sps_port and sps_peer compiled before this file
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module sps_port_tb_top;
    import sps_pkg::*;
    logic        clk_i, nrst_i, psel_i, penable_i, pwrite_i;
    logic [7:0]  paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic        pready_o, pslverr_o, irq_o, sck, sd, ss_n;
    logic        pin_sck_o, pin_sck_oe_o, pin_sd_o, pin_sd_oe_o, pin_sdo_o, pin_sdo_oe_o;
    logic [2:0]  gpio_out_i, gpio_oe_i;
    int          miscompares, checks_done, cycles;

    sps_port i_sps_port (
        .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .pin_sck_i(pin_sck_oe_o ? pin_sck_o : sck), .pin_sd_i(pin_sd_oe_o ? pin_sd_o : sd),
        .pin_ss_n_i(ss_n), .pin_sck_o(pin_sck_o), .pin_sck_oe_o(pin_sck_oe_o),
        .pin_sd_o(pin_sd_o), .pin_sd_oe_o(pin_sd_oe_o), .pin_sdo_o(pin_sdo_o),
        .pin_sdo_oe_o(pin_sdo_oe_o), .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i),
        .irq_o(irq_o)
    );
    sps_peer i_sps_peer (.sck_o(sck), .sd_o(sd), .ss_n_o(ss_n));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    // one apb transfer; read data compared under mask m
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        `CHK(pready_o, 1'b1)
        `CHK(pslverr_o, e)
        if (!w) `CHK(prdata_o & m, d)
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // detection takes a few clocks after the pin edge
    task automatic settle();
        repeat (8) @(posedge clk_i);
    endtask

    initial begin
        {nrst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        gpio_out_i = 3'h5;
        gpio_oe_i  = 3'h7;
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        acc(0, OFS_STATUS, 32'h0, '1, 0);
        acc(0, 8'hB0, 32'h0, '1, 1);
        acc(1, OFS_STATUS, 32'hFF, '1, 1);
        acc(0, OFS_STATUS, 32'h0, '1, 0);
        acc(0, OFS_IRQ_STAT, 32'h0, '1, 0);
        `CHK({pin_sdo_o, pin_sd_o, pin_sck_o, pin_sdo_oe_o, pin_sd_oe_o, pin_sck_oe_o}, 6'h2F)
        // released bus idles high; a low gpio sd would fake a stop on enable
        gpio_out_i <= 3'h7;
        acc(1, OFS_IRQ_MASK, 32'h7, '1, 0);
        acc(1, OFS_CTRL, 32'h21, '1, 0);
        acc(0, OFS_CTRL, 32'h21, '1, 0);
        settle();
        `CHK({pin_sd_oe_o, pin_sck_oe_o}, 2'b00)
        i2c_start_chk();
        i_sps_peer.i2c_byte(8'hA5);
        settle();
        acc(0, OFS_STATUS, 32'h0D, '1, 0);
        acc(0, OFS_IRQ_STAT, 32'h3, '1, 0);
        acc(0, OFS_BUF, 32'hA5, '1, 0);
        acc(0, OFS_STATUS, 32'h0C, '1, 0);
        acc(1, OFS_IRQ_STAT, 32'h7, '1, 0);
        // irq settles one edge after the write lands
        @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        i_sps_peer.i2c_byte(8'h5A);
        settle();
        acc(0, OFS_STATUS, 32'h29, 32'h39, 0);
        i_sps_peer.i2c_stop();
        settle();
        acc(0, OFS_STATUS, 32'h10, 32'h18, 0);
        i2c_start_chk();
        acc(1, OFS_CTRL, 32'h01, '1, 0);
        settle();
        acc(0, OFS_STATUS, 32'h0, 32'h18, 0);
        i_sps_peer.i2c_start();
        settle();
        acc(0, OFS_STATUS, 32'h0, 32'h18, 0);
        for (int k = 0; k < 2; k++) begin
            acc(1, OFS_CTRL, 32'h20 | (k << 4), '1, 0);
            acc(1, OFS_BUF, 32'h80, '1, 0);
            settle();
            `CHK(pin_sdo_o, 1'b1)
            i_sps_peer.spi_byte(k[0], 8'hC3 ^ k[7:0]);
            settle();
            acc(0, OFS_STATUS, 32'h1, 32'h19, 0);
            acc(0, OFS_BUF, 32'hC3 ^ k, '1, 0);
            acc(0, OFS_STATUS, 32'h0, 32'h1, 0);
        end
        acc(1, OFS_IRQ_MASK, 32'h0, '1, 0);
        @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        acc(1, OFS_IRQ_MASK, 32'h1, '1, 0);
        @(posedge clk_i);
        `CHK(irq_o, 1'b1)
        conclude();
    end

    // start seen last: flag set, stop flag clear, interrupt raised
    task automatic i2c_start_chk();
        i_sps_peer.i2c_start();
        settle();
        acc(0, OFS_STATUS, 32'h08, 32'h18, 0);
        `CHK(irq_o, 1'b1)
    endtask
endmodule
